// ### src/pcc_map.svh
// Register map, field positions and reset values of the clock and power controller
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

// Byte offsets
`define PCC_OFF_CTRL 12'h000
`define PCC_OFF_STAT 12'h004
`define PCC_OFF_WAKE 12'h008

// Control register fields
`define PCC_CONV_EN_BIT 2
`define PCC_SERIAL_EN_BIT 3
`define PCC_EVENT_EN_BIT 4
`define PCC_RATIO_LSB 9
`define PCC_RATIO_MSB 11
`define PCC_PSEL_LSB 12
`define PCC_PSEL_MSB 13

// Reset values
`define PCC_RATIO_RESET 3'h7
`define PCC_PSEL_RESET 2'h0
`define PCC_PERIPH_EN_RESET 1'h0

// Wake cause bits
`define PCC_WAKE_PERIPH_BIT 0
`define PCC_WAKE_EXT_BIT 1
`define PCC_WAKE_WAKEUP_BIT 2
`define PCC_WAKE_PROTECT_BIT 3

// Timing counts in ref_clk cycles
`define PCC_OSC_SETTLE_CYCLES 8'h10

`endif

// ### src/pcc_pkg.sv
// Types shared by the clock and power controller
package pcc_pkg;

	typedef struct packed {
		logic cpu;
		logic sys;
		logic wdog;
		logic pll;
		logic osc;
	} pcc_domain_en_type;

	typedef struct packed {
		logic conv;
		logic serial;
		logic event_unit;
	} pcc_periph_en_type;

	typedef struct packed {
		logic [2:0] num;
		logic [2:0] den;
	} pcc_ratio_type;

	typedef enum logic [5:0] {
		PCC_RUN = 6'h01,
		PCC_CPU_STOP = 6'h02,
		PCC_DUAL_STOP = 6'h04,
		PCC_HALT = 6'h08,
		PCC_OSC_START = 6'h10,
		PCC_SYS_START = 6'h20
	} pcc_state_type;

endpackage : pcc_pkg

// ### src/pcc_ratio_gen.sv
// Ratio code to PLL multiply and divide settings
`timescale 1ns/10ps
`include "pcc_map.svh"
module pcc_ratio_gen
	import pcc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Ratio code
	input wire logic [2:0] ratioCode,
	// PLL setting
	output pcc_ratio_type pllRatio
);

	function automatic pcc_ratio_type decodeRatio(input logic [2:0] code);
		pcc_ratio_type r;
		r = '{num: 3'h1, den: 3'h2};
		case (code)
			3'h0: r = '{num: 3'h4, den: 3'h1};
			3'h1: r = '{num: 3'h2, den: 3'h1};
			3'h2: r = '{num: 3'h4, den: 3'h3};
			3'h3: r = '{num: 3'h1, den: 3'h1};
			3'h4: r = '{num: 3'h4, den: 3'h5};
			3'h5: r = '{num: 3'h2, den: 3'h3};
			3'h6: r = '{num: 3'h4, den: 3'h7};
			default: r = '{num: 3'h1, den: 3'h2};
		endcase
		return r;
	endfunction : decodeRatio

	pcc_ratio_type ratioNext;

	assign ratioNext = decodeRatio(ratioCode);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pllRatio <= decodeRatio(`PCC_RATIO_RESET);
		end else begin
			pllRatio <= ratioNext;
		end
	end

endmodule : pcc_ratio_gen

// ### src/pcc_pin_sync.sv
// Three-stage synchroniser with agreement check for a pin
`timescale 1ns/10ps
module pcc_pin_sync (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Raw pin and resolved level
	input wire logic pinRaw,
	output logic pinLevel
);

	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;
	logic agree;

	assign agree = (stage2_reg == stage3_reg);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stage1_reg <= 1'h1;
			stage2_reg <= 1'h1;
			stage3_reg <= 1'h1;
			pinLevel <= 1'h1;
		end else begin
			stage1_reg <= pinRaw;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			if (agree) begin
				pinLevel <= stage3_reg;
			end
		end
	end

endmodule : pcc_pin_sync

// ### src/pcc_top.sv
// Clock ratio, domain gating and low-power mode controller with APB registers
`timescale 1ns/10ps
`include "pcc_map.svh"

module pcc_top
	import pcc_pkg::*;
#(
	parameter logic [7:0] OSC_SETTLE = `PCC_OSC_SETTLE_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU and wake sources
	input wire logic idleExec,
	input wire logic periphIrq,
	input wire logic extIrq,
	input wire logic wakeIrq,
	input wire logic power_drive_protect_pin_n,
	// Clock control outputs
	output pcc_domain_en_type domainEn,
	output pcc_periph_en_type periphEn,
	output pcc_ratio_type pllRatio,
	output logic flashPowerAuto
);

	// Control fields
	logic [2:0] ratio_reg;
	logic [2:0] ratio_next;
	logic [1:0] powerSel_reg;
	logic [1:0] powerSel_next;
	pcc_periph_en_type periphEn_next;
	logic [3:0] wakeCause_reg;
	logic [3:0] wakeCause_next;
	pcc_state_type state_reg;
	pcc_state_type state_next;
	logic [7:0] settle_reg;
	logic [7:0] settle_next;
	pcc_domain_en_type domainEn_next;
	logic ctrlWrite;
	logic wakeClear;
	logic inStop;
	logic settleDone;
	logic [7:0] settleDec;

	// Bus decode
	logic access;
	logic wrStrobe;
	logic rdStrobe;
	logic hitCtrl;
	logic hitStat;
	logic hitWake;
	logic hitAny;
	logic [31:0] ctrlWord;
	logic [31:0] statWord;
	logic [31:0] wakeWord;
	logic [31:0] readMux;

	// Wake logic
	logic protectLevel;
	logic protectActive;
	logic wakeCpuStop;
	logic wakeDual;
	logic wakeHalt;
	logic [3:0] wakeEvents;
	logic power_select_high;
	logic power_select_low;

	// Protect pin synchroniser
	pcc_pin_sync u_protect_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pinRaw(power_drive_protect_pin_n),
		.pinLevel(protectLevel)
	);

	pcc_ratio_gen u_ratio_gen (
		.ref_clk(ref_clk),
		.rst(rst),
		.ratioCode(ratio_reg),
		.pllRatio(pllRatio)
	);

	// Register decode
	assign access = psel & penable & ~pready;
	assign wrStrobe = access & pwrite;
	assign rdStrobe = access & ~pwrite;
	assign hitCtrl = (paddr == `PCC_OFF_CTRL);
	assign hitStat = (paddr == `PCC_OFF_STAT);
	assign hitWake = (paddr == `PCC_OFF_WAKE);
	assign hitAny = hitCtrl | hitStat | hitWake;
	assign ctrlWrite = wrStrobe & hitCtrl;
	assign wakeClear = wrStrobe & hitWake;

	assign power_select_high = powerSel_reg[1];
	assign power_select_low = powerSel_reg[0];

	assign ctrlWord = {18'h0, powerSel_reg, ratio_reg, 4'h0, periphEn.event_unit,
		periphEn.serial, periphEn.conv, 2'h0};
	assign statWord = {21'h0, domainEn, state_reg};
	assign wakeWord = {28'h0, wakeCause_reg};
	assign readMux = hitCtrl ? ctrlWord :
		hitStat ? statWord :
		hitWake ? wakeWord : 32'h0;

	// Control register writes
	assign ratio_next = ctrlWrite ? pwdata[`PCC_RATIO_MSB:`PCC_RATIO_LSB] : ratio_reg;
	assign powerSel_next = ctrlWrite ? pwdata[`PCC_PSEL_MSB:`PCC_PSEL_LSB] : powerSel_reg;
	assign periphEn_next = ctrlWrite ?
		pcc_periph_en_type'{conv: pwdata[`PCC_CONV_EN_BIT], serial: pwdata[`PCC_SERIAL_EN_BIT],
		event_unit: pwdata[`PCC_EVENT_EN_BIT]} : periphEn;

	// Wake sources
	assign protectActive = ~protectLevel;
	assign wakeEvents = {protectActive, wakeIrq, extIrq, periphIrq};
	assign wakeCpuStop = periphIrq | extIrq | protectActive;
	assign wakeDual = wakeIrq | extIrq | protectActive;
	assign wakeHalt = protectActive;

	// Wake cause, set wins over write-one clear
	assign inStop = (state_reg == PCC_CPU_STOP) | (state_reg == PCC_DUAL_STOP) |
		(state_reg == PCC_HALT);
	assign wakeCause_next = (wakeCause_reg & ~(wakeClear ? pwdata[3:0] : 4'h0)) |
		(inStop ? wakeEvents : 4'h0);

	// Oscillator settle count
	assign settleDone = (settle_reg == 8'h0);
	assign settleDec = settle_reg - 8'h1;

	// Mode sequencing
	always_comb begin
		state_next = state_reg;
		settle_next = settle_reg;
		case (state_reg)
			PCC_RUN: begin
				if (idleExec) begin
					if (power_select_high) begin
						state_next = PCC_HALT;
					end else if (power_select_low) begin
						state_next = PCC_DUAL_STOP;
					end else begin
						state_next = PCC_CPU_STOP;
					end
				end
			end
			PCC_CPU_STOP: begin
				if (wakeCpuStop) begin
					state_next = PCC_RUN;
				end
			end
			PCC_DUAL_STOP: begin
				if (wakeDual) begin
					state_next = PCC_SYS_START;
				end
			end
			PCC_HALT: begin
				if (wakeHalt) begin
					state_next = PCC_OSC_START;
					settle_next = OSC_SETTLE;
				end
			end
			PCC_OSC_START: begin
				if (settleDone) begin
					state_next = PCC_SYS_START;
				end else begin
					settle_next = settleDec;
				end
			end
			PCC_SYS_START: begin
				state_next = PCC_RUN;
			end
			default: begin
				state_next = PCC_RUN;
			end
		endcase
	end

	// Domain enables per state
	function automatic pcc_domain_en_type domainFor(input pcc_state_type st);
		pcc_domain_en_type d;
		d = '{cpu: 1'h1, sys: 1'h1, wdog: 1'h1, pll: 1'h1, osc: 1'h1};
		case (st)
			PCC_RUN: begin
				d = '{cpu: 1'h1, sys: 1'h1, wdog: 1'h1, pll: 1'h1, osc: 1'h1};
			end
			PCC_CPU_STOP: begin
				d = '{cpu: 1'h0, sys: 1'h1, wdog: 1'h1, pll: 1'h1, osc: 1'h1};
			end
			PCC_DUAL_STOP: begin
				d = '{cpu: 1'h0, sys: 1'h0, wdog: 1'h1, pll: 1'h1, osc: 1'h1};
			end
			PCC_HALT: begin
				d = '{cpu: 1'h0, sys: 1'h0, wdog: 1'h0, pll: 1'h0, osc: 1'h0};
			end
			PCC_OSC_START: begin
				d = '{cpu: 1'h0, sys: 1'h0, wdog: 1'h1, pll: 1'h1, osc: 1'h1};
			end
			PCC_SYS_START: begin
				d = '{cpu: 1'h0, sys: 1'h1, wdog: 1'h1, pll: 1'h1, osc: 1'h1};
			end
			default: begin
				d = '{cpu: 1'h1, sys: 1'h1, wdog: 1'h1, pll: 1'h1, osc: 1'h1};
			end
		endcase
		return d;
	endfunction : domainFor

	assign domainEn_next = domainFor(state_next);

	// Control register state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ratio_reg <= `PCC_RATIO_RESET;
			powerSel_reg <= `PCC_PSEL_RESET;
			periphEn <= '{conv: `PCC_PERIPH_EN_RESET, serial: `PCC_PERIPH_EN_RESET,
				event_unit: `PCC_PERIPH_EN_RESET};
		end else begin
			ratio_reg <= ratio_next;
			powerSel_reg <= powerSel_next;
			periphEn <= periphEn_next;
		end
	end

	// Sticky wake causes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wakeCause_reg <= 4'h0;
		end else begin
			wakeCause_reg <= wakeCause_next;
		end
	end

	// Mode sequencer state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= PCC_RUN;
			settle_reg <= 8'h0;
		end else begin
			state_reg <= state_next;
			settle_reg <= settle_next;
		end
	end

	// Clock enables to the domains
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			domainEn <= domainFor(PCC_RUN);
			flashPowerAuto <= 1'h1;
		end else begin
			domainEn <= domainEn_next;
			// Flash power stays up; no register turns it off
			flashPowerAuto <= 1'h1;
		end
	end

	// APB answer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h0;
		end else begin
			pready <= access;
			pslverr <= access & ~hitAny;
			prdata <= rdStrobe ? readMux : 32'h0;
		end
	end

endmodule : pcc_top

// ### tb/pcc_top_sva.sv
// Assertions for the clock and power controller
`timescale 1ns/10ps
module pcc_top_sva
	import pcc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Wake sources
	input wire logic idleExec,
	input wire logic periphIrq,
	input wire logic extIrq,
	input wire logic power_drive_protect_pin_n,
	// Clock control
	input pcc_domain_en_type domainEn,
	input pcc_periph_en_type periphEn,
	input pcc_ratio_type pllRatio,
	input logic flashPowerAuto
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_RESET_VAL: assert property ($fell(rst) |-> pllRatio == 6'h0a && periphEn == 3'h0)
		else $error("reset values wrong");
	AST_IDLE_CPU: assert property (idleExec && domainEn == 5'h1f |=> !domainEn.cpu)
		else $error("cpu clock not stopped");
	AST_LEGAL: assert property (domainEn inside {5'h1f, 5'h0f, 5'h07, 5'h00})
		else $error("illegal domain mix");
	AST_IRQ_WAKE: assert property (domainEn == 5'h0f && (periphIrq || extIrq) |=> domainEn == 5'h1f)
		else $error("no wake from cpu stop");
	AST_SYS_FIRST: assert property ($rose(domainEn.cpu) |-> $past(domainEn.sys))
		else $error("cpu restarted before system");
	AST_DUAL_BOTH: assert property ($fell(domainEn.sys) |-> !domainEn.cpu)
		else $error("system stopped alone");
	AST_HALT_HOLD: assert property (power_drive_protect_pin_n [*5] ##0 domainEn == 5'h00 |=> domainEn == 5'h00)
		else $error("halt left without pin");
	AST_OSC_FIRST: assert property ($rose(domainEn.osc) |-> domainEn == 5'h07 ##1 domainEn == 5'h07)
		else $error("oscillator start too short");
	AST_FLASH_ON: assert property (flashPowerAuto)
		else $error("flash power removed");
	cover property (domainEn == 5'h0f);
	cover property (domainEn == 5'h00);
	cover property ($rose(domainEn.osc));
endmodule : pcc_top_sva

bind pcc_top pcc_top_sva chk(.ref_clk, .rst, .idleExec, .periphIrq, .extIrq,
	.power_drive_protect_pin_n, .domainEn, .periphEn, .pllRatio, .flashPowerAuto);

// ### tb/testbench.sv
// Self-checking bench for the clock and power controller
`timescale 1ns/10ps
module testbench;
	import pcc_pkg::*;
	logic ref_clk, rst, psel, penable, pwrite, idleExec, periphIrq, extIrq, wakeIrq, pinN;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, flashPowerAuto;
	pcc_domain_en_type domainEn;
	pcc_periph_en_type periphEn;
	pcc_ratio_type pllRatio;
	int errors, check_count, i;
	logic [5:0] ratioTab [8] = '{6'h21, 6'h11, 6'h23, 6'h09, 6'h25, 6'h13, 6'h27, 6'h0a};
	logic [4:0] stopTab [4] = '{5'h0f, 5'h07, 5'h00, 5'h00};
	logic [5:0] stateTab [4] = '{6'h02, 6'h04, 6'h08, 6'h08};
	pcc_top #(.OSC_SETTLE(8'h02)) uut(.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .idleExec, .periphIrq, .extIrq, .wakeIrq,
		.power_drive_protect_pin_n(pinN), .domainEn, .periphEn, .pllRatio, .flashPowerAuto);
	task give_verdict;
		if (errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task idle(input logic [1:0] s);
		apb(1'b1, 12'h000, {18'h0, s, 3'h0, 9'h01c}, rd, err);
		idleExec <= 1'b1;
		@(posedge ref_clk);
		idleExec <= 1'b0;
		@(posedge ref_clk);
	endtask : idle
	task waitRun;
		int n;
		for (n = 0; n < 60 && domainEn !== 5'h1f; n++) @(posedge ref_clk);
		chk(32'(domainEn), 32'h1f);
	endtask : waitRun
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		errors++;
		give_verdict;
	end
	initial begin
		{rst, psel, penable, pwrite, idleExec, periphIrq, extIrq, wakeIrq} = 8'h80;
		{paddr, pwdata} = '0;
		pinN = 1'b1;
		errors = 0;
		check_count = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk(32'(pllRatio), 32'h0a);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		chk(rd, 32'h0e00);
		apb(1'b0, 12'h0f0, 32'h0, rd, err);
		chk({rd[30:0], err}, 32'h1);
		for (i = 0; i < 8; i++) begin
			apb(1'b1, 12'h000, {20'h0, i[2:0], 9'h01c}, rd, err);
			@(posedge ref_clk);
			chk(32'(pllRatio), 32'(ratioTab[i]));
		end
		chk(32'(periphEn), 32'h7);
		for (i = 0; i < 4; i++) begin
			idle(i[1:0]);
			chk(32'(domainEn), 32'(stopTab[i]));
			wakeIrq <= (i != 1);
			periphIrq <= (i != 0);
			extIrq <= (i > 1);
			repeat (3) @(posedge ref_clk);
			chk(32'(domainEn), 32'(stopTab[i]));
			apb(1'b0, 12'h004, 32'h0, rd, err);
			chk(rd, 32'({stopTab[i], stateTab[i]}));
			chk(32'(flashPowerAuto), 32'h1);
			wakeIrq <= (i == 1);
			periphIrq <= (i == 0);
			extIrq <= 1'b0;
			pinN <= (i < 2);
			waitRun;
			{wakeIrq, periphIrq, pinN} <= 3'h1;
			repeat (6) @(posedge ref_clk);
		end
		apb(1'b0, 12'h008, 32'h0, rd, err);
		chk(rd, 32'h0f);
		apb(1'b1, 12'h008, 32'h0f, rd, err);
		apb(1'b0, 12'h008, 32'h0, rd, err);
		chk({rd[30:0], err}, 32'h0);
		idle(2'h0);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk(32'(domainEn), 32'h1f);
		chk(32'({periphEn, pllRatio}), 32'h0a);
		give_verdict;
	end
endmodule : testbench
